// >>> core/amss_dev.sv
// amss_dev: control mode capture and setting source selection
// assumes: clk is the master clock; register values come from a bus slave
// What this block does
// - release with bus lines not both low: combined
// - release with both bus lines low: pin-only
// - master clock must run before reset release
// - reset low clears state and registers
// - enable low mutes, outputs high impedance
// - enable must be high to operate
// - format pins zero: register or I2S
// - format register resets to I2S
// - nonzero format pins pick fixed formats
// - rate pin low: register or 256fs; high 512fs
// - wrong clock rate may switch output off
// - sample pin low: register or 48k; high 96k
// - gain pins zero: register or mute
// - gain code 3F is +12 dB, 1.5 dB steps
// - pin gain uses register gain encoding
// - mute pin low: register or mute; high releases
// - test pins must stay low
// - slave only, scl input, never stretched
// - sda needs external pull-up
// - pin-only mode ignores the registers
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "amss_cfg.svh"
module amss_dev
  import amss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  amss_if.dev pins,
  // register values from the bus slave
  input wire logic reg_load,
  input wire logic [2:0] reg_fmt,
  input wire logic [1:0] reg_mck,
  input wire logic [1:0] reg_sr,
  input wire logic [5:0] reg_gain_l,
  input wire logic [5:0] reg_gain_r,
  input wire logic reg_mute_n_l,
  input wire logic reg_mute_n_r,
  // clock rate check from the data path
  input wire logic mclk_rate_bad,
  // resolved settings
  output amss_mode_t mode,
  output amss_fmt_t fmt,
  output logic [1:0] mck_rate,
  output logic [1:0] samp_rate,
  output amss_gain_t gain_l,
  output amss_gain_t gain_r,
  output logic mute_l,
  output logic mute_r,
  output logic pwm_oe
);
  logic rst_n;
  logic running;
  amss_fmt_t r_fmt;
  logic [1:0] r_mck;
  logic [1:0] r_sr;
  amss_gain_t r_gl;
  amss_gain_t r_gr;
  logic r_ml_n;
  logic r_mr_n;
  logic bus_ok;
  logic next_mute_l;
  logic next_mute_r;

  // shared types must match the pin groups they carry
  if (`AMSS_FMT_W != 3 || `AMSS_GAIN_W != 6 || `AMSS_MCKR_W != 2 || `AMSS_SAMPLE_RATE_SEL_W != 2)
  begin : g_width_check
    $error("setting widths do not match the pin groups");
  end

  // ==========================================
  // reset and mode capture
  // both resets clear everything
  assign rst_n = nrst & pins.hw_reset_n;
  // no bus engine in this block, so the data line is only ever released
  // sda never driven except by a bus slave outside; scl only read
  assign pins.sda_dev_oe = 1'b0;

  // first cycle after release marks the capture point
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      running <= 1'b0;
    else
      running <= 1'b1;

  // capture once at release, held afterwards
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mode <= AMSS_MODE_COMBINED;
    else if (!running)
      mode <= (!pins.scl && !pins.sda) ? AMSS_MODE_PIN_ONLY : AMSS_MODE_COMBINED;

  // ==========================================
  // register copies
  // stand-in for the bus register file; loaded whole on one strobe
  // register copies reset to their initial values
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      r_fmt <= `AMSS_RST_FMT;
      r_mck <= `AMSS_RST_MCK;
      r_sr <= `AMSS_RST_SR;
      r_gl <= `AMSS_RST_GAIN;
      r_gr <= `AMSS_RST_GAIN;
      r_ml_n <= `AMSS_RST_MUTE_N;
      r_mr_n <= `AMSS_RST_MUTE_N;
    end
    else if (reg_load)
    begin
      r_fmt <= reg_fmt;
      r_mck <= reg_mck;
      r_sr <= reg_sr;
      r_gl <= reg_gain_l;
      r_gr <= reg_gain_r;
      r_ml_n <= reg_mute_n_l;
      r_mr_n <= reg_mute_n_r;
    end

  // ==========================================
  // setting selection
  // a pin group away from its zero code always wins over the register
  // registers count only in combined mode
  assign bus_ok = (mode == AMSS_MODE_COMBINED);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      fmt <= `AMSS_RST_FMT;
    else if (pins.format_sel != 3'h0)
      fmt <= pins.format_sel;
    else
      fmt <= bus_ok ? r_fmt : `AMSS_FMT_I2S;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mck_rate <= `AMSS_RST_MCK;
    else if (pins.mclk_rate_sel)
      mck_rate <= `AMSS_MCK_512;
    else
      mck_rate <= bus_ok ? r_mck : `AMSS_MCK_256;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      samp_rate <= `AMSS_RST_SR;
    else if (pins.sample_rate_sel)
      samp_rate <= `AMSS_SR_96;
    else
      samp_rate <= bus_ok ? r_sr : `AMSS_SR_48;

  // pin gain drives both channels in the register encoding
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      gain_l <= `AMSS_RST_GAIN;
      gain_r <= `AMSS_RST_GAIN;
    end
    else if (pins.vol_code != 6'h00)
    begin
      gain_l <= pins.vol_code;
      gain_r <= pins.vol_code;
    end
    else
    begin
      gain_l <= bus_ok ? r_gl : `AMSS_GAIN_MUTE;
      gain_r <= bus_ok ? r_gr : `AMSS_GAIN_MUTE;
    end

  // ==========================================
  // mute and output stage
  // mute reads the registered gain, so it lags a gain change by one cycle
  // mute pin shared by both channels
  // enable low forces mute whatever the gain
  // a bad clock rate also silences the output
  always_comb
  begin
    next_mute_l = pins.soft_mute_n ? 1'b0 : !(bus_ok && r_ml_n);
    next_mute_r = pins.soft_mute_n ? 1'b0 : !(bus_ok && r_mr_n);
    if (!pins.sys_enable || mclk_rate_bad || gain_l == `AMSS_GAIN_MUTE)
      next_mute_l = 1'b1;
    if (!pins.sys_enable || mclk_rate_bad || gain_r == `AMSS_GAIN_MUTE)
      next_mute_r = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mute_l <= 1'b1;
      mute_r <= 1'b1;
    end
    else
    begin
      mute_l <= next_mute_l;
      mute_r <= next_mute_r;
    end

  // pwm outputs released to high impedance while enable is low or the clock rate is bad
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pwm_oe <= 1'b0;
    else
      pwm_oe <= pins.sys_enable & ~mclk_rate_bad;
endmodule : amss_dev
`default_nettype wire

// >>> pkg/amss_cfg.svh
// amss_cfg.svh: reset values, codes and field layout of the setting selector
// assumes: included by its bare name from the package and design files
`ifndef AMSS_CFG_SVH
`define AMSS_CFG_SVH

`define AMSS_FMT_W 3
`define AMSS_GAIN_W 6
`define AMSS_MCKR_W 2
`define AMSS_SAMPLE_RATE_SEL_W 2
// format codes
`define AMSS_FMT_I2S 3'h0
`define AMSS_FMT_LJ 3'h1
`define AMSS_FMT_RJ_LSB 3'h2
`define AMSS_FMT_RJ24 3'h3
`define AMSS_FMT_RJ20 3'h4
`define AMSS_FMT_RJ18 3'h5
`define AMSS_FMT_RJ16 3'h6
// master clock rate codes
`define AMSS_MCK_256 2'h0
`define AMSS_MCK_384 2'h1
`define AMSS_MCK_512 2'h2
`define AMSS_MCK_768 2'h3
// sample rate codes
`define AMSS_SR_32 2'h0
`define AMSS_SR_48 2'h1
`define AMSS_SR_96 2'h2
`define AMSS_SR_192 2'h3
// gain: 0 is mute, 3F is +12.0 dB, 37 is 0 dB, 1.5 dB a step
`define AMSS_GAIN_MUTE 6'h00
`define AMSS_GAIN_0DB 6'h37
// register reset values
`define AMSS_RST_FMT `AMSS_FMT_I2S
`define AMSS_RST_MCK `AMSS_MCK_256
`define AMSS_RST_SR `AMSS_SR_48
`define AMSS_RST_GAIN `AMSS_GAIN_MUTE
`define AMSS_RST_MUTE_N 1'b0
// controller register offsets (byte addresses)
`define AMSS_REG_CTRL 12'h000
`define AMSS_REG_PINS 12'h004
`define AMSS_REG_STAT 12'h008
// CTRL fields
`define AMSS_CTRL_RST_N 0
`define AMSS_CTRL_EN 1
`define AMSS_CTRL_SCL 2
`define AMSS_CTRL_SDA 3
// PINS fields
`define AMSS_PINS_FMT 0
`define AMSS_PINS_MCK 3
`define AMSS_PINS_SR 4
`define AMSS_PINS_GAIN 8
`define AMSS_PINS_MUTE_N 14
`define AMSS_PINS_TEST 15
`define AMSS_PINS_MODE 16

`endif

// >>> pkg/amss_pkg.sv
// amss_pkg: types shared by both ends of the setting selector
// assumes: amss_cfg.svh on the include path
`include "amss_cfg.svh"
package amss_pkg;
  typedef enum logic {AMSS_MODE_COMBINED = 1'b0, AMSS_MODE_PIN_ONLY = 1'b1} amss_mode_t;
  typedef logic [`AMSS_FMT_W-1:0] amss_fmt_t;
  typedef logic [`AMSS_GAIN_W-1:0] amss_gain_t;
endpackage : amss_pkg

// >>> pkg/amss_if.sv
// amss_if: configuration pins between board controller and amplifier
// assumes: one clock shared by both ends; sda is open drain, resolved here
`timescale 1ns/1ps
`default_nettype none
interface amss_if;
  logic hw_reset_n;
  logic sys_enable;
  logic [2:0] format_sel;
  logic mclk_rate_sel;
  logic sample_rate_sel;
  logic [5:0] vol_code;
  logic soft_mute_n;
  logic test_sel;
  logic mode_sel;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;
  // open drain with pull-up: low while any end drives
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport dev (input hw_reset_n, sys_enable, format_sel, mclk_rate_sel, sample_rate_sel,
    vol_code, soft_mute_n, test_sel, mode_sel, scl, sda, output sda_dev_oe);
  modport host (output hw_reset_n, sys_enable, format_sel, mclk_rate_sel, sample_rate_sel,
    vol_code, soft_mute_n, test_sel, mode_sel, scl, sda_host_oe, input sda);
endinterface : amss_if
`default_nettype wire

// >>> core/amss_host.sv
// amss_host: board controller driving the amplifier configuration pins
// assumes: APB master on clk; clk also serves as the master clock to the device
`timescale 1ns/1ps
`default_nettype none
`include "amss_cfg.svh"
module amss_host
  import amss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  amss_if.host pins
);
  logic [3:0] ctrl;
  logic [16:0] pin_reg;
  logic acc;
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign pslverr = acc & (paddr != `AMSS_REG_CTRL) & (paddr != `AMSS_REG_PINS)
    & (paddr != `AMSS_REG_STAT);

  // ==========================================
  // apb registers
  // device held in reset, enable high, bus lines idle high
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      ctrl <= 4'hE;
    else if (acc && pwrite && paddr == `AMSS_REG_CTRL)
      ctrl <= pwdata[3:0];

  // test pins kept low whatever software writes
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      pin_reg <= 17'h00000;
    else if (acc && pwrite && paddr == `AMSS_REG_PINS)
      pin_reg <= {2'b00, pwdata[14:0]};

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      case (paddr)
        `AMSS_REG_CTRL: prdata <= {28'h0000000, ctrl};
        `AMSS_REG_PINS: prdata <= {15'h0000, pin_reg};
        `AMSS_REG_STAT: prdata <= {31'h00000000, pins.sda};
        default: prdata <= 32'h00000000;
      endcase

  // ==========================================
  // pin drive
  // reset release only by software, clock already running
  assign pins.hw_reset_n = ctrl[`AMSS_CTRL_RST_N];
  assign pins.sys_enable = ctrl[`AMSS_CTRL_EN];
  assign pins.scl = ctrl[`AMSS_CTRL_SCL];
  // open drain: only ever pulls low
  assign pins.sda_host_oe = ~ctrl[`AMSS_CTRL_SDA];
  assign pins.format_sel = pin_reg[`AMSS_PINS_FMT +: 3];
  assign pins.mclk_rate_sel = pin_reg[`AMSS_PINS_MCK];
  assign pins.sample_rate_sel = pin_reg[`AMSS_PINS_SR];
  assign pins.vol_code = pin_reg[`AMSS_PINS_GAIN +: 6];
  assign pins.soft_mute_n = pin_reg[`AMSS_PINS_MUTE_N];
  assign pins.test_sel = pin_reg[`AMSS_PINS_TEST];
  assign pins.mode_sel = pin_reg[`AMSS_PINS_MODE];
endmodule : amss_host
`default_nettype wire

// >>> tb/amss_properties.sv
// amss_properties: timing checks on the pins and the resolved settings
// assumes: one clk; settings follow their sources one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "amss_cfg.svh"
module amss_properties
  import amss_pkg::*;
(
  // clock, reset, pins
  input wire logic clk,
  input wire logic nrst,
  input wire logic hw_reset_n,
  input wire logic sys_enable,
  input wire logic [2:0] format_sel,
  input wire logic mclk_rate_sel,
  input wire logic sample_rate_sel,
  input wire logic [5:0] vol_code,
  input wire logic soft_mute_n,
  input wire logic scl,
  input wire logic sda,
  // resolved settings
  input wire amss_mode_t mode,
  input wire amss_fmt_t fmt,
  input wire logic [1:0] mck_rate,
  input wire logic [1:0] samp_rate,
  input wire amss_gain_t gain_l,
  input wire amss_gain_t gain_r,
  input wire logic mute_l,
  input wire logic mute_r,
  input wire logic pwm_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || !hw_reset_n);
  // ==========================================
  // mode capture
  sequence s_release;
    !hw_reset_n ##1 hw_reset_n;
  endsequence
  // settled: one edge past the capture edge
  sequence s_run;
    $past(hw_reset_n) && hw_reset_n;
  endsequence
  property p_pin_mode;
    disable iff (!nrst) s_release ##0 (!scl && !sda) |=> mode == AMSS_MODE_PIN_ONLY;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin-only mode missed");
  property p_comb_mode;
    disable iff (!nrst) s_release ##0 (scl || sda) |=> mode == AMSS_MODE_COMBINED;
  endproperty
  a_comb_mode: assert property (p_comb_mode) else $error("combined mode missed");
  property p_mode_hold;
    s_run |=> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
  property p_reset;
    disable iff (!nrst) !hw_reset_n |-> mode == AMSS_MODE_COMBINED && fmt == 3'h0
      && !pwm_oe && mute_l && mute_r;
  endproperty
  a_reset: assert property (p_reset) else $error("state kept in reset");
  // ==========================================
  // pin decoding
  property p_enable;
    s_run ##0 !sys_enable |=> !pwm_oe && mute_l && mute_r;
  endproperty
  a_enable: assert property (p_enable) else $error("disabled yet driving");
  property p_fmt_pin;
    s_run ##0 format_sel != 3'h0 |=> fmt == $past(format_sel);
  endproperty
  a_fmt_pin: assert property (p_fmt_pin) else $error("format pins ignored");
  property p_pin_only;
    s_run ##0 mode == AMSS_MODE_PIN_ONLY && format_sel == 3'h0 && !mclk_rate_sel
      && !sample_rate_sel |=> fmt == `AMSS_FMT_I2S && mck_rate == `AMSS_MCK_256
      && samp_rate == `AMSS_SR_48;
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("pin-only default wrong");
  property p_rate;
    s_run ##0 mclk_rate_sel && sample_rate_sel |=> mck_rate == `AMSS_MCK_512
      && samp_rate == `AMSS_SR_96;
  endproperty
  a_rate: assert property (p_rate) else $error("rate pins ignored");
  property p_gain;
    s_run ##0 vol_code != 6'h00 |=> gain_l == $past(vol_code) && gain_r == $past(vol_code);
  endproperty
  a_gain: assert property (p_gain) else $error("gain pins ignored");
  property p_mute;
    s_run ##0 mode == AMSS_MODE_PIN_ONLY && !soft_mute_n |=> mute_l && mute_r;
  endproperty
  a_mute: assert property (p_mute) else $error("mute pin ignored");
endmodule : amss_properties
`default_nettype wire

// >>> tb/amss_test.sv
// amss_test: host and device joined; APB drives the host
// assumes: 50 MHz clk; clock rate check driven by the bench
`timescale 1ns/1ps
`default_nettype none
`include "amss_cfg.svh"
module amss_test
  import amss_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reg_load = 1'b0, rate_bad = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [20:0] rv = 21'h000000;
  logic pready, pslverr, mute_l, mute_r, pwm_oe;
  logic [1:0] mck_rate, samp_rate;
  amss_mode_t mode;
  amss_fmt_t fmt;
  amss_gain_t gain_l, gain_r;
  logic [23:0] st;
  int miscompares = 0, check_count = 0;
  // pins word in 39:24, settings in 23:0; register copies set to 15E042
  logic [39:0] rows [7] = '{40'h000015E041, 40'h771B0EB7DC, 40'h3F0105FFFD,
    40'h410619C104, 40'h400209E040, 40'h400411E040, 40'h400515E040};
  assign st = {3'h0, fmt, mck_rate, samp_rate, gain_l, gain_r, mute_l, mute_r};
  always #10 clk = ~clk;
  amss_if amss_if_i ();
  amss_host amss_host_i (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins(amss_if_i));
  amss_dev amss_dev_i (.clk, .nrst, .pins(amss_if_i), .reg_load, .reg_fmt(rv[20:18]),
    .reg_mck(rv[17:16]), .reg_sr(rv[15:14]), .reg_gain_l(rv[13:8]), .reg_gain_r(rv[7:2]),
    .reg_mute_n_l(rv[1]), .reg_mute_n_r(rv[0]), .mclk_rate_bad(rate_bad), .mode, .fmt,
    .mck_rate, .samp_rate, .gain_l, .gain_r, .mute_l, .mute_r, .pwm_oe);
  amss_properties amss_properties_i (.clk, .nrst, .hw_reset_n(amss_if_i.hw_reset_n),
    .sys_enable(amss_if_i.sys_enable), .format_sel(amss_if_i.format_sel),
    .mclk_rate_sel(amss_if_i.mclk_rate_sel), .sample_rate_sel(amss_if_i.sample_rate_sel),
    .vol_code(amss_if_i.vol_code), .soft_mute_n(amss_if_i.soft_mute_n), .scl(amss_if_i.scl),
    .sda(amss_if_i.sda), .mode, .fmt, .mck_rate, .samp_rate, .gain_l, .gain_r, .mute_l,
    .mute_r, .pwm_oe);
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load(input logic [20:0] v);
    @(posedge clk);
    rv <= v;
    reg_load <= 1'b1;
    @(posedge clk);
    reg_load <= 1'b0;
  endtask : load
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ==========================================
  // sequence
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, pwm_oe}, 32'h0);
    apb(1'b1, 12'h000, 32'hF);
    repeat (3) @(posedge clk);
    chk({31'h0, mode}, 32'h0);
    chk({8'h00, st}, 32'h004003);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hF);
    // unmapped word must be refused
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    // test pin bits never reach the pins word
    apb(1'b1, 12'h004, 32'h0001C000);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00004000);
    $display("test reset done");
    load(21'h15E042);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h004, {16'h0, rows[i][39:24]});
      repeat (3) @(posedge clk);
      chk({8'h00, st}, {8'h00, rows[i][23:0]});
    end
    $display("test table done");
    // release with both bus lines low
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h000, 32'hF);
    load(21'h0ABCDF);
    apb(1'b1, 12'h004, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, mode}, 32'h1);
    chk({8'h00, st}, 32'h004003);
    apb(1'b1, 12'h004, 32'h771B);
    repeat (3) @(posedge clk);
    chk({8'h00, st}, 32'h0EB7DC);
    chk({29'h0, pwm_oe, mute_l, mute_r}, 32'h4);
    $display("test pin-only done");
    rate_bad <= 1'b1;
    repeat (3) @(posedge clk);
    chk({29'h0, pwm_oe, mute_l, mute_r}, 32'h3);
    rate_bad <= 1'b0;
    repeat (3) @(posedge clk);
    chk({29'h0, pwm_oe, mute_l, mute_r}, 32'h4);
    $display("test clock rate done");
    apb(1'b1, 12'h000, 32'hD);
    repeat (3) @(posedge clk);
    chk({29'h0, pwm_oe, mute_l, mute_r}, 32'h3);
    $display("test enable done");
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    final_report();
  end
endmodule : amss_test
`default_nettype wire
